/* include/tmif_pkg.sv */
// tmif_pkg: constants and types for the timer interrupt mask and flag block
// assumes a 32-bit apb master and timer units that supply per-instance events
package tmif_pkg;

	// register word indices; byte address is four times the index
	localparam logic [9:0] TMIF_IDX_T1_MASK  = 10'h06f;
	localparam logic [9:0] TMIF_IDX_T3_MASK  = 10'h071;
	localparam logic [9:0] TMIF_IDX_T1_FLAGS = 10'h040;
	localparam logic [9:0] TMIF_IDX_T3_FLAGS = 10'h041;

	// bit positions shared by mask and flag registers
	localparam int TMIF_BIT_CAPTURE  = 5;
	localparam int TMIF_BIT_CMP_B    = 2;
	localparam int TMIF_BIT_CMP_A    = 1;
	localparam int TMIF_BIT_OVERFLOW = 0;

	// source order in the four-bit vector and request groups
	localparam int TMIF_SRC_OVERFLOW = 0;
	localparam int TMIF_SRC_CMP_A    = 1;
	localparam int TMIF_SRC_CMP_B    = 2;
	localparam int TMIF_SRC_CAPTURE  = 3;

	localparam logic [7:0] TMIF_IMPL_BITS  = 8'h27;
	localparam logic [7:0] TMIF_RESET_MASK = 8'h00;
	localparam logic [7:0] TMIF_RESET_FLAG = 8'h00;

	// waveform modes in which overflow is the plain counter wrap
	localparam logic [3:0] TMIF_WGM_NORMAL   = 4'h0;
	localparam logic [3:0] TMIF_WGM_CTC_CMPA = 4'h4;
	localparam logic [3:0] TMIF_WGM_CTC_CAPT = 4'hc;

	// one-hot register select
	localparam int TMIF_SEL_T1_MASK  = 0;
	localparam int TMIF_SEL_T3_MASK  = 1;
	localparam int TMIF_SEL_T1_FLAGS = 2;
	localparam int TMIF_SEL_T3_FLAGS = 3;

	typedef struct packed {
		logic       capture;
		logic       capture_top_mode;
		logic       at_top;
		logic       match_a;
		logic       match_b;
		logic       force_a;
		logic       force_b;
		logic       tick;
		logic       overflow;
		logic       mode_overflow;
		logic [3:0] waveform_mode_field;
	} tmif_event_type;

	typedef struct packed {
		logic [1:0][7:0] mask;
		logic [1:0][7:0] flags;
		logic [1:0]      pend_a;
		logic [1:0]      pend_b;
		logic [1:0][3:0] irq;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} tmif_state_type;

endpackage

/* rtl/tmif_timer_irq.sv */
// tmif_timer_irq: mask and flag registers for timer instances 1 and 3
// assumes apb on pclk and timer event inputs synchronous to pclk
`timescale 1ns/100ps
`default_nettype none

module tmif_timer_irq
	import tmif_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 global_irq_en,
	input  wire tmif_event_type [1:0] timer_events,
	input  wire logic [1:0][3:0]      vector_taken,
	output logic      [1:0][3:0]      irq_request
);

	tmif_state_type  state_reg;
	tmif_state_type  state_next;
	logic [3:0]      sel;
	logic            wr_en;
	logic [1:0][7:0] flag_set;
	logic [1:0][7:0] flag_clr;

	function automatic logic [3:0] decode(input logic [11:0] addr);
		logic [9:0] idx;
		idx = addr[11:2];
		decode = 4'h0;
		if (idx == TMIF_IDX_T1_MASK) begin
			decode[TMIF_SEL_T1_MASK] = 1'b1;
		end else if (idx == TMIF_IDX_T3_MASK) begin
			decode[TMIF_SEL_T3_MASK] = 1'b1;
		end else if (idx == TMIF_IDX_T1_FLAGS) begin
			decode[TMIF_SEL_T1_FLAGS] = 1'b1;
		end else if (idx == TMIF_IDX_T3_FLAGS) begin
			decode[TMIF_SEL_T3_FLAGS] = 1'b1;
		end
	endfunction

	function automatic logic [7:0] expand(input logic [3:0] src);
		expand = 8'h00;
		expand[TMIF_BIT_CAPTURE]  = src[TMIF_SRC_CAPTURE];
		expand[TMIF_BIT_CMP_B]    = src[TMIF_SRC_CMP_B];
		expand[TMIF_BIT_CMP_A]    = src[TMIF_SRC_CMP_A];
		expand[TMIF_BIT_OVERFLOW] = src[TMIF_SRC_OVERFLOW];
	endfunction

	function automatic logic [3:0] compress(input logic [7:0] bits);
		compress = 4'h0;
		compress[TMIF_SRC_CAPTURE]  = bits[TMIF_BIT_CAPTURE];
		compress[TMIF_SRC_CMP_B]    = bits[TMIF_BIT_CMP_B];
		compress[TMIF_SRC_CMP_A]    = bits[TMIF_BIT_CMP_A];
		compress[TMIF_SRC_OVERFLOW] = bits[TMIF_BIT_OVERFLOW];
	endfunction

	function automatic logic wrap_mode(input logic [3:0] wgm);
		wrap_mode = (wgm == TMIF_WGM_NORMAL) || (wgm == TMIF_WGM_CTC_CMPA)
			|| (wgm == TMIF_WGM_CTC_CAPT);
	endfunction

	assign sel   = decode(paddr);
	// one wait-free access cycle: pready rises in the cycle after setup
	assign wr_en = psel && penable && pwrite && state_reg.pready;

	always_comb begin
		state_next = state_reg;
		flag_set   = '0;
		flag_clr   = '0;
		state_next.pready = psel && !penable;
		if (psel && !penable) begin
			state_next.prdata  = 32'h0000_0000;
			state_next.pslverr = 1'b0;
			if (sel[TMIF_SEL_T1_MASK]) begin
				state_next.prdata[7:0] = state_reg.mask[0];
			end else if (sel[TMIF_SEL_T3_MASK]) begin
				state_next.prdata[7:0] = state_reg.mask[1];
			end else if (sel[TMIF_SEL_T1_FLAGS]) begin
				state_next.prdata[7:0] = state_reg.flags[0];
			end else if (sel[TMIF_SEL_T3_FLAGS]) begin
				state_next.prdata[7:0] = state_reg.flags[1];
			end else begin
				state_next.pslverr = 1'b1;
			end
		end
		for (int i = 0; i < 2; i++) begin
			// instance 1 in slot 0, instance 3 in slot 1
			if (wr_en && sel[TMIF_SEL_T1_MASK + i]) begin
				state_next.mask[i] = pwdata[7:0] & TMIF_IMPL_BITS;
			end
			if (wr_en && sel[TMIF_SEL_T1_FLAGS + i]) begin
				flag_clr[i] = pwdata[7:0];
			end
			flag_clr[i] = flag_clr[i] | expand(vector_taken[i]);
			if (timer_events[i].capture_top_mode) begin
				// capture pin is disconnected while it defines top
				flag_set[i][TMIF_BIT_CAPTURE] = timer_events[i].at_top;
			end else begin
				flag_set[i][TMIF_BIT_CAPTURE] = timer_events[i].capture;
			end
			// match is held for one timer tick before the flag rises
			if (timer_events[i].tick) begin
				state_next.pend_a[i] = timer_events[i].match_a
					&& !timer_events[i].force_a;
				state_next.pend_b[i] = timer_events[i].match_b
					&& !timer_events[i].force_b;
				flag_set[i][TMIF_BIT_CMP_A] = state_reg.pend_a[i];
				flag_set[i][TMIF_BIT_CMP_B] = state_reg.pend_b[i];
			end
			if (wrap_mode(timer_events[i].waveform_mode_field)) begin
				flag_set[i][TMIF_BIT_OVERFLOW] = timer_events[i].overflow;
			end else begin
				flag_set[i][TMIF_BIT_OVERFLOW] = timer_events[i].mode_overflow;
			end
			state_next.flags[i] = ((state_reg.flags[i] & ~flag_clr[i])
				| flag_set[i]) & TMIF_IMPL_BITS;
			// built from next values so the request has no extra lag
			state_next.irq[i] = global_irq_en
				? compress(state_next.flags[i] & state_next.mask[i])
				: 4'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg        <= '0;
			state_reg.mask   <= {TMIF_RESET_MASK, TMIF_RESET_MASK};
			state_reg.flags  <= {TMIF_RESET_FLAG, TMIF_RESET_FLAG};
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata      = state_reg.prdata;
	assign pready      = state_reg.pready;
	assign pslverr     = state_reg.pslverr;
	assign irq_request = state_reg.irq;

	sequence s_t1_mask_wr;
		wr_en && sel[TMIF_SEL_T1_MASK];
	endsequence

	sequence s_t3_mask_wr;
		wr_en && sel[TMIF_SEL_T3_MASK];
	endsequence

	sequence s_match_a_seen;
		timer_events[0].tick && timer_events[0].match_a
			&& !timer_events[0].force_a;
	endsequence

	sequence s_match_b_seen;
		timer_events[0].tick && timer_events[0].match_b
			&& !timer_events[0].force_b;
	endsequence

	sequence s_match_a3_seen;
		timer_events[1].tick && timer_events[1].match_a
			&& !timer_events[1].force_a;
	endsequence

	AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		((state_reg.mask[0] | state_reg.mask[1] | state_reg.flags[0]
		| state_reg.flags[1]) & ~TMIF_IMPL_BITS) == 8'h00)
		else $error("reserved bit seen as one");

	AST_MASK1_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		s_t1_mask_wr |=> state_reg.mask[0] == ($past(pwdata[7:0]) & TMIF_IMPL_BITS))
		else $error("instance 1 mask write not stored");

	AST_MASK3_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		s_t3_mask_wr |=> state_reg.mask[1] == ($past(pwdata[7:0]) & TMIF_IMPL_BITS)
		&& $stable(state_reg.mask[0]))
		else $error("instance 3 mask write wrong");

	AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		irq_request[0] == ($past(global_irq_en)
		? compress(state_reg.flags[0] & state_reg.mask[0]) : 4'h0))
		else $error("request not gated by enable and flag");

	AST_CAPTURE_SET: assert property (@(posedge pclk) disable iff (!presetn)
		timer_events[0].capture && !timer_events[0].capture_top_mode
		|=> state_reg.flags[0][TMIF_BIT_CAPTURE])
		else $error("capture event did not set flag");

	AST_CAPTURE_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		timer_events[0].capture_top_mode && !timer_events[0].at_top
		&& !state_reg.flags[0][TMIF_BIT_CAPTURE]
		|=> !state_reg.flags[0][TMIF_BIT_CAPTURE])
		else $error("capture flag set without top in top mode");

	AST_CMP_A_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		s_match_a_seen ##1 timer_events[0].tick
		|=> state_reg.flags[0][TMIF_BIT_CMP_A])
		else $error("compare a flag not set one tick later");

	AST_CMP_B_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		s_match_b_seen ##1 timer_events[0].tick
		|=> state_reg.flags[0][TMIF_BIT_CMP_B])
		else $error("compare b flag not set one tick later");

	AST_FORCE_NO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		timer_events[0].tick && timer_events[0].force_a
		|=> !state_reg.pend_a[0])
		else $error("forced compare armed a flag");

	AST_OVF_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		timer_events[0].overflow
		&& timer_events[0].waveform_mode_field == TMIF_WGM_NORMAL
		|=> state_reg.flags[0][TMIF_BIT_OVERFLOW])
		else $error("overflow flag missed in normal mode");

	AST_VECTOR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		vector_taken[0][TMIF_SRC_OVERFLOW] && !timer_events[0].overflow
		&& !timer_events[0].mode_overflow
		|=> !state_reg.flags[0][TMIF_BIT_OVERFLOW])
		else $error("vector did not clear overflow flag");

	AST_W1C_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && sel[TMIF_SEL_T1_FLAGS] && pwdata[TMIF_BIT_CAPTURE]
		|=> state_reg.flags[0][TMIF_BIT_CAPTURE]
		== $past(timer_events[0].capture && !timer_events[0].capture_top_mode
		|| timer_events[0].at_top && timer_events[0].capture_top_mode))
		else $error("write one clear or set priority wrong");

	AST_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && sel[TMIF_SEL_T1_FLAGS] && !pwdata[TMIF_BIT_CAPTURE]
		&& state_reg.flags[0][TMIF_BIT_CAPTURE]
		&& !vector_taken[0][TMIF_SRC_CAPTURE]
		|=> state_reg.flags[0][TMIF_BIT_CAPTURE])
		else $error("writing zero cleared a flag");

	AST_MASK_RESET: assert property (@(posedge pclk)
		!presetn |=> state_reg.mask == '0 || $past(presetn))
		else $error("mask not zero after reset");

	AST_IRQ_GATE3: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_request[1] == ($past(global_irq_en)
		? compress(state_reg.flags[1] & state_reg.mask[1]) : 4'h0))
		else $error("instance 3 request not gated");

	AST_CAPTURE_SET3: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[1].capture && !timer_events[1].capture_top_mode
		|=> state_reg.flags[1][TMIF_BIT_CAPTURE])
		else $error("instance 3 capture event did not set flag");

	AST_TOP_SETS_FLAG: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[0].capture_top_mode && timer_events[0].at_top
		|=> state_reg.flags[0][TMIF_BIT_CAPTURE])
		else $error("reaching top did not set capture flag");

	AST_CMP_A_DELAY3: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_match_a3_seen ##1 timer_events[1].tick
		|=> state_reg.flags[1][TMIF_BIT_CMP_A])
		else $error("instance 3 compare a flag not set one tick later");

	AST_FORCE_B_NO_FLAG: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[0].tick && timer_events[0].force_b
		|=> !state_reg.pend_b[0])
		else $error("forced compare armed b flag");

	AST_FORCE_NO_FLAG3: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[1].tick && timer_events[1].force_a
		&& timer_events[1].force_b
		|=> !state_reg.pend_a[1] && !state_reg.pend_b[1])
		else $error("instance 3 forced compare armed a flag");

	AST_OVF_MODE: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[0].mode_overflow
		&& !wrap_mode(timer_events[0].waveform_mode_field)
		|=> state_reg.flags[0][TMIF_BIT_OVERFLOW])
		else $error("overflow flag missed in other mode");

	AST_OVF_WRAP3: assert property (
		@(posedge pclk) disable iff (!presetn)
		timer_events[1].overflow
		&& wrap_mode(timer_events[1].waveform_mode_field)
		|=> state_reg.flags[1][TMIF_BIT_OVERFLOW])
		else $error("instance 3 overflow flag missed");

	AST_VECTOR_CLEAR_A: assert property (
		@(posedge pclk) disable iff (!presetn)
		vector_taken[0][TMIF_SRC_CMP_A]
		&& !(timer_events[0].tick && state_reg.pend_a[0])
		|=> !state_reg.flags[0][TMIF_BIT_CMP_A])
		else $error("vector did not clear compare a flag");

	AST_VECTOR_CLEAR_CAP: assert property (
		@(posedge pclk) disable iff (!presetn)
		vector_taken[0][TMIF_SRC_CAPTURE] && !timer_events[0].capture
		&& !timer_events[0].at_top
		|=> !state_reg.flags[0][TMIF_BIT_CAPTURE])
		else $error("vector did not clear capture flag");

	AST_W1C_CLEAR3: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && sel[TMIF_SEL_T3_FLAGS] && pwdata[TMIF_BIT_OVERFLOW]
		&& !timer_events[1].overflow && !timer_events[1].mode_overflow
		|=> !state_reg.flags[1][TMIF_BIT_OVERFLOW])
		else $error("instance 3 write one did not clear flag");

	AST_W0_KEEP3: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && sel[TMIF_SEL_T3_FLAGS] && !pwdata[TMIF_BIT_OVERFLOW]
		&& state_reg.flags[1][TMIF_BIT_OVERFLOW]
		&& !vector_taken[1][TMIF_SRC_OVERFLOW]
		|=> state_reg.flags[1][TMIF_BIT_OVERFLOW])
		else $error("instance 3 writing zero cleared a flag");

	AST_RD_RSVD: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:8] == 24'h00_0000 && prdata[7:6] == 2'h0
		&& prdata[4:3] == 2'h0)
		else $error("read data shows a reserved bit");

	AST_MASK1_KEEP: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(wr_en && sel[TMIF_SEL_T1_MASK]) |=> $stable(state_reg.mask[0]))
		else $error("instance 1 mask changed without a write");

endmodule // tmif_timer_irq

`default_nettype wire

/* testbench/tmif_event_src.sv */
// tmif_event_src: timer event source standing beside the irq block
// assumes one request at a time, raised by the bench right after an edge
`timescale 1ns/100ps
`default_nettype none

module tmif_event_src
	import tmif_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            go,
	input  wire logic            inst,
	input  wire logic [2:0]      kind,
	output var tmif_event_type [1:0] ev
);
	logic       go_q;
	logic [1:0] tail;

	// pulses last one cycle; a compare tick follows its match a cycle later
	always @(posedge pclk) begin
		ev <= '0;
		tail <= '0;
		go_q <= go;
		for (int i = 0; i < 2; i++)
			if (tail[i]) ev[i].tick <= 1'b1;
		if (go && !go_q) begin
			case (kind)
			3'd0: ev[inst].overflow <= 1'b1;
			3'd1: begin
				ev[inst].match_a <= 1'b1;
				ev[inst].tick <= 1'b1;
				tail[inst] <= 1'b1;
			end
			3'd2: begin
				ev[inst].match_b <= 1'b1;
				ev[inst].tick <= 1'b1;
				tail[inst] <= 1'b1;
			end
			3'd3: ev[inst].capture <= 1'b1;
			3'd4: begin
				ev[inst].capture_top_mode <= 1'b1;
				ev[inst].at_top <= 1'b1;
			end
			3'd5: begin
				ev[inst].waveform_mode_field <= 4'h1;
				ev[inst].mode_overflow <= 1'b1;
			end
			3'd6: begin
				// forced strobes land on the matching tick
				ev[inst].match_a <= 1'b1;
				ev[inst].match_b <= 1'b1;
				ev[inst].force_a <= 1'b1;
				ev[inst].force_b <= 1'b1;
				ev[inst].tick <= 1'b1;
				tail[inst] <= 1'b1;
			end
			default: begin
				ev[inst].waveform_mode_field <= 4'h1;
				ev[inst].overflow <= 1'b1;
			end
			endcase
		end
	end
endmodule // tmif_event_src

`default_nettype wire

/* testbench/tb_timer_irq_mask_flag_logic.sv */
// tb_timer_irq_mask_flag_logic: self-checking bench for the irq block
// assumes the bench is apb master and tmif_event_src makes timer events
`timescale 1ns/100ps
`default_nettype none

module tb_timer_irq_mask_flag_logic
	import tmif_pkg::*;
;
	logic                 pclk, presetn, psel, penable, pwrite;
	logic                 gie, go, inst, er, pready, pslverr;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic [2:0]           kind;
	logic [1:0][3:0]      vtak, irq, ei;
	tmif_event_type [1:0] ev;
	int                   n_errors = 0;
	int                   n_compared = 0;
	// kind in 10:8, expected flags in 7:0; kinds 6 and 7 must set nothing
	logic [10:0] rows [8] = '{11'h001, 11'h102, 11'h204, 11'h320,
		11'h420, 11'h501, 11'h600, 11'h700};

	tmif_timer_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .global_irq_en(gie), .timer_events(ev),
		.vector_taken(vtak), .irq_request(irq));
	tmif_event_src u_src (.pclk(pclk), .go(go), .inst(inst), .kind(kind),
		.ev(ev));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	function automatic logic [3:0] f2i(input logic [7:0] f);
		return {f[5], f[2], f[1], f[0]};
	endfunction
	function automatic logic [9:0] midx(input int i);
		return i ? TMIF_IDX_T3_MASK : TMIF_IDX_T1_MASK;
	endfunction
	function automatic logic [9:0] fidx(input int i);
		return i ? TMIF_IDX_T3_FLAGS : TMIF_IDX_T1_FLAGS;
	endfunction

	task automatic end_sim;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// entered right after a rising edge; holds the request until pready
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [7:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, rd, er);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, rd, er);
		chk(rd, {24'h0, exp});
	endtask
	task automatic fire(input logic [2:0] k, input logic i);
		kind <= k;
		inst <= i;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, gie, go, inst} = '0;
		paddr = '0;
		pwdata = '0;
		kind = '0;
		vtak = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 2; i++) begin
			rdc(midx(i), 8'h00);
			rdc(fidx(i), 8'h00);
			wr(midx(i), 8'hff);
			rdc(midx(i), 8'h27);
			wr(fidx(i), 8'hff);
			rdc(fidx(i), 8'h00);
		end
		apb(1'b0, 10'h000, 8'h00, rd, er);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		gie <= 1'b1;
		for (int i = 0; i < 2; i++)
			for (int r = 0; r < 8; r++) begin
				fire(rows[r][10:8], i[0]);
				ei = '0;
				ei[i] = f2i(rows[r][7:0]);
				chk({24'h0, irq}, {24'h0, ei});
				rdc(fidx(i), rows[r][7:0]);
				wr(fidx(i), 8'h00);
				rdc(fidx(i), rows[r][7:0]);
				wr(fidx(i), rows[r][7:0]);
				rdc(fidx(i), 8'h00);
			end
		gie <= 1'b0;
		fire(3'd1, 1'b1);
		chk({28'h0, irq[1]}, 32'h0);
		gie <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({28'h0, irq[1]}, 32'h2);
		wr(TMIF_IDX_T3_MASK, 8'h25);
		repeat (2) @(posedge pclk);
		chk({28'h0, irq[1]}, 32'h0);
		for (int s = 0; s < 4; s++) begin
			fire(s[2:0], 1'b0);
			vtak[0][s] <= 1'b1;
			@(posedge pclk);
			vtak[0] <= '0;
			rdc(TMIF_IDX_T1_FLAGS, 8'h00);
		end
		// event edge lines up with the access edge of the clearing write
		kind <= 3'd0;
		inst <= 1'b0;
		go <= 1'b1;
		wr(TMIF_IDX_T1_FLAGS, 8'h01);
		go <= 1'b0;
		rdc(TMIF_IDX_T1_FLAGS, 8'h01);
		// mid-run reset must drop a written mask and a set flag
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(TMIF_IDX_T3_MASK, 8'h00);
		rdc(TMIF_IDX_T1_FLAGS, 8'h00);
		end_sim;
	end

	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		end_sim;
	end
endmodule // tb_timer_irq_mask_flag_logic

`default_nettype wire
